// ===== rtl/iop_pkg.sv
// shared constants and carrier types for the six-pin i/o port
package iop_pkg;

	localparam int IOP_PINS = 6;

	// pin positions of the alternate functions
	localparam int PIN_I2C_SCL = 0;
	localparam int PIN_I2C_SDA = 1;
	localparam int PIN_SHARED2 = 2;
	localparam int PIN_SHARED3 = 3;
	localparam int PIN_SHARED4 = 4;
	localparam int PIN_SHARED5 = 5;

	// strap patterns on pins 1..0
	localparam logic [1:0] STRAP_DEBUG = 2'h1;
	localparam logic [1:0] STRAP_PROGRAM = 2'h2;

	// configuration reset values
	localparam logic [5:0] RST_DIR = 6'h00;
	localparam logic [5:0] RST_DATA = 6'h00;
	localparam logic [5:0] RST_PULL_UP = 6'h00;
	localparam logic [5:0] RST_PULL_DOWN = 6'h00;
	localparam logic [5:0] RST_WAKE_EN = 6'h00;
	localparam logic [5:0] RST_WAKE_LEVEL = 6'h00;

	// input synchroniser depth, and the wait before straps are taken
	localparam int SYNC_DEPTH = 3;
	localparam logic [2:0] BOOT_SETTLE = 3'h4;

	typedef enum logic [2:0] {
		BOOT_NORMAL = 3'h1,
		BOOT_DEBUG = 3'h2,
		BOOT_PROGRAM = 3'h4
	} iop_boot_type;

	typedef enum logic [1:0] {
		STRAP_WAIT = 2'h1,
		STRAP_DONE = 2'h2
	} iop_strap_state_type;

	// software configuration, one bit per pin
	typedef struct packed {
		logic [5:0] dir;
		logic [5:0] data;
		logic [5:0] pull_up;
		logic [5:0] pull_down;
		logic [5:0] wake_en;
		logic [5:0] wake_level;
	} iop_cfg_type;

	// alternate function enables
	typedef struct packed {
		logic i2c_pin_enable;
		logic uart_enable;
		logic spi_enable;
		logic spi_dma_master;
		logic pwm_enable;
		logic rf_serial_out_pin_enable;
		logic external_sysclk_input;
	} iop_alt_en_type;

	// levels that the peripherals want on the pins
	typedef struct packed {
		logic i2c_scl_low;
		logic i2c_sda_low;
		logic uart_tx;
		logic spi_ssn_out;
		logic spi_mosi_out;
		logic spi_mosi_drive;
		logic spi_miso_out;
		logic spi_miso_drive;
		logic spi_sclk_out;
		logic spi_sclk_drive;
		logic pwm_ch0;
		logic pwm_ch1;
		logic rf_tx_data;
	} iop_alt_drv_type;

	// pin levels handed back to the peripherals
	typedef struct packed {
		logic i2c_scl_in;
		logic i2c_sda_in;
		logic uart_rx_in;
		logic spi_ssn_in;
		logic spi_mosi_in;
		logic spi_miso_in;
		logic spi_sclk_in;
		logic ext_clk_in;
	} iop_alt_in_type;

endpackage

// ===== rtl/iop_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module iop_sync3 #(
	parameter int WIDTH = 6
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [WIDTH-1:0] async_in, // raw pin levels
	output logic [WIDTH-1:0] level // filtered levels
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit moves only when stages two and three agree; stage one feeds nothing else
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	end
endmodule

// ===== rtl/iop_port.sv
// six-pin general purpose port with boot straps, wake-up and pin multiplexing
//
// Contract
// - six pins, each readable and writable by software.
// - straps on pins 1..0 at power-up: 01 debug, 10 programming, else normal.
// - any pin can wake from power-down or resume from idle.
// - i2c enabled puts clock on pin 0 and data on pin 1.
// - uart enabled drives transmit on pin 3, takes receive from pin 4.
// - spi enabled: pin 2 select, pin 3 mosi, pin 4 miso, pin 5 clock.
// - pwm enabled drives channel 0 on pin 2, channel 1 on pin 4.
// - each pin has its own pull-up and pull-down selection.
// - configuration holds unchanged in power-down and thermal shutdown.
// - i2c pin enable turns pin 0 into the i2c clock.
// - i2c lines idle high through internal pull-up or external master.
// - i2c pin enable turns pin 1 into the i2c data line.
// - rf serial out pin enable drives encoder output onto pin 2.
// - spi select pin is input in non-dma mode, output as dma master.
// - pin 5 can serve as external system clock input.
`timescale 1ns/1ps

module iop_port
	import iop_pkg::*;
#(
	parameter int PINS = IOP_PINS
) (
	input wire logic clk, // system clock, 50 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic cfg_write, // one-cycle strobe: load cfg_in
	input wire iop_cfg_type cfg_in, // configuration to load
	input wire logic power_down, // device in power-down state
	input wire logic thermal_shutdown, // device in thermal shutdown state
	input wire logic idle, // device in idle state
	input wire iop_alt_en_type alt_en, // alternate function enables
	input wire iop_alt_drv_type alt_drv, // peripheral levels toward pins
	input wire logic [PINS-1:0] pin_in, // pin input levels
	output logic [PINS-1:0] pin_out, // pin output levels
	output logic [PINS-1:0] pin_oe_n, // pin output enable, low drives
	output logic [PINS-1:0] pull_up, // pull-up resistor enables
	output logic [PINS-1:0] pull_down, // pull-down resistor enables
	output logic [PINS-1:0] pin_read, // filtered pin levels for software
	output iop_cfg_type cfg_out, // configuration readback
	output iop_alt_in_type alt_in, // pin levels toward peripherals
	output logic wake_request, // wake or resume request level
	output iop_boot_type boot_mode, // strapped boot mode
	output logic boot_valid // boot_mode has been taken
);
	iop_cfg_type cfg;
	logic [PINS-1:0] level;
	logic [PINS-1:0] next_out;
	logic [PINS-1:0] next_oe_n;
	logic [PINS-1:0] wake_hit;
	iop_strap_state_type strap_state;
	logic [2:0] settle;

	iop_sync3 #(
		.WIDTH(PINS)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pin_in),
		.level(level)
	);

	////////////////////////////////////////////////////////////////////////////
	// configuration store

	// writes are dropped while frozen so the pins keep their state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg.dir <= RST_DIR;
			cfg.data <= RST_DATA;
			cfg.pull_up <= RST_PULL_UP;
			cfg.pull_down <= RST_PULL_DOWN;
			cfg.wake_en <= RST_WAKE_EN;
			cfg.wake_level <= RST_WAKE_LEVEL;
		end else if (cfg_write && !power_down && !thermal_shutdown) begin
			cfg <= cfg_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_out <= '0;
			pin_read <= '0;
		end else begin
			cfg_out <= cfg;
			pin_read <= level;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// resistors

	// both set selects neither, so the pin is never fought by its own resistors
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pull_up <= '0;
			pull_down <= '0;
		end else begin
			pull_up <= cfg.pull_up & ~cfg.pull_down;
			pull_down <= cfg.pull_down & ~cfg.pull_up;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin multiplexer

	always_comb begin
		next_out = cfg.data;
		next_oe_n = ~cfg.dir;
		// pins 0 and 1: open drain, only ever pulled low
		if (alt_en.i2c_pin_enable) begin
			next_out[PIN_I2C_SCL] = 1'b0;
			next_oe_n[PIN_I2C_SCL] = ~alt_drv.i2c_scl_low;
			next_out[PIN_I2C_SDA] = 1'b0;
			next_oe_n[PIN_I2C_SDA] = ~alt_drv.i2c_sda_low;
		end
		// pin 2: rf, then spi select, then pwm channel 0
		if (alt_en.rf_serial_out_pin_enable) begin
			next_out[PIN_SHARED2] = alt_drv.rf_tx_data;
			next_oe_n[PIN_SHARED2] = 1'b0;
		end else if (alt_en.spi_enable) begin
			next_out[PIN_SHARED2] = alt_drv.spi_ssn_out;
			next_oe_n[PIN_SHARED2] = ~alt_en.spi_dma_master;
		end else if (alt_en.pwm_enable) begin
			next_out[PIN_SHARED2] = alt_drv.pwm_ch0;
			next_oe_n[PIN_SHARED2] = 1'b0;
		end
		// pin 3: spi mosi, then uart transmit
		if (alt_en.spi_enable) begin
			next_out[PIN_SHARED3] = alt_drv.spi_mosi_out;
			next_oe_n[PIN_SHARED3] = ~alt_drv.spi_mosi_drive;
		end else if (alt_en.uart_enable) begin
			next_out[PIN_SHARED3] = alt_drv.uart_tx;
			next_oe_n[PIN_SHARED3] = 1'b0;
		end
		// pin 4: spi miso, then uart receive, then pwm channel 1
		if (alt_en.spi_enable) begin
			next_out[PIN_SHARED4] = alt_drv.spi_miso_out;
			next_oe_n[PIN_SHARED4] = ~alt_drv.spi_miso_drive;
		end else if (alt_en.uart_enable) begin
			next_out[PIN_SHARED4] = 1'b0;
			next_oe_n[PIN_SHARED4] = 1'b1;
		end else if (alt_en.pwm_enable) begin
			next_out[PIN_SHARED4] = alt_drv.pwm_ch1;
			next_oe_n[PIN_SHARED4] = 1'b0;
		end
		// pin 5: external clock input, then spi clock
		if (alt_en.external_sysclk_input) begin
			next_out[PIN_SHARED5] = 1'b0;
			next_oe_n[PIN_SHARED5] = 1'b1;
		end else if (alt_en.spi_enable) begin
			next_out[PIN_SHARED5] = alt_drv.spi_sclk_out;
			next_oe_n[PIN_SHARED5] = ~alt_drv.spi_sclk_drive;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_out <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out <= next_out;
			pin_oe_n <= next_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// levels toward peripherals

	// gated by enable so a disabled peripheral sees a quiet line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alt_in <= '0;
		end else begin
			alt_in.i2c_scl_in <= alt_en.i2c_pin_enable & level[PIN_I2C_SCL];
			alt_in.i2c_sda_in <= alt_en.i2c_pin_enable & level[PIN_I2C_SDA];
			alt_in.uart_rx_in <= alt_en.uart_enable & ~alt_en.spi_enable & level[PIN_SHARED4];
			alt_in.spi_ssn_in <= alt_en.spi_enable & ~alt_en.spi_dma_master & level[PIN_SHARED2];
			alt_in.spi_mosi_in <= alt_en.spi_enable & level[PIN_SHARED3];
			alt_in.spi_miso_in <= alt_en.spi_enable & level[PIN_SHARED4];
			alt_in.spi_sclk_in <= alt_en.spi_enable & ~alt_en.external_sysclk_input & level[PIN_SHARED5];
			// limitation: the clock is filtered, so it must run well below clk / 4
			alt_in.ext_clk_in <= alt_en.external_sysclk_input & level[PIN_SHARED5];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wake-up

	assign wake_hit = cfg.wake_en & ~(cfg.wake_level ^ level);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= (|wake_hit) & (power_down | idle);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// boot straps

	// straps are taken once the filter has settled, never under reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strap_state <= STRAP_WAIT;
			settle <= 3'h0;
			boot_mode <= BOOT_NORMAL;
			boot_valid <= 1'b0;
		end else begin
			case (strap_state)
				STRAP_WAIT: begin
					if (settle == BOOT_SETTLE) begin
						strap_state <= STRAP_DONE;
						boot_valid <= 1'b1;
						if (level[PIN_I2C_SDA:PIN_I2C_SCL] == STRAP_DEBUG) begin
							boot_mode <= BOOT_DEBUG;
						end else if (level[PIN_I2C_SDA:PIN_I2C_SCL] == STRAP_PROGRAM) begin
							boot_mode <= BOOT_PROGRAM;
						end else begin
							boot_mode <= BOOT_NORMAL;
						end
					end else begin
						settle <= settle + 3'h1;
					end
				end
				STRAP_DONE: begin
					strap_state <= STRAP_DONE;
				end
				default: begin
					strap_state <= STRAP_WAIT;
				end
			endcase
		end
	end
endmodule

// ===== testbench/iop_port_asserts.sv
// concurrent checks on the port mux, configuration and boot straps
`timescale 1ns/1ps
module iop_chk
	import iop_pkg::*;
#(
	parameter int PINS = IOP_PINS
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic cfg_write, // write strobe
	input wire iop_cfg_type cfg_in, // new config
	input wire logic power_down, // power-down
	input wire logic thermal_shutdown, // thermal stop
	input wire iop_alt_en_type alt_en, // enables
	input wire iop_alt_drv_type alt_drv, // peripheral levels
	input wire logic [PINS-1:0] pin_out, // pin levels
	input wire logic [PINS-1:0] pin_oe_n, // drive enables
	input wire logic [PINS-1:0] pull_up, // pull-ups
	input wire logic [PINS-1:0] pull_down, // pull-downs
	input wire iop_cfg_type cfg_out, // readback
	input wire iop_boot_type boot_mode, // boot mode
	input wire logic boot_valid // boot taken
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_frozen; (power_down || thermal_shutdown) [*3]; endsequence
	// window is loose on purpose: the release edge count is only fixed to a cycle or two
	sequence s_boot; !boot_valid ##[3:8] boot_valid; endsequence
	property p_cfg; cfg_write && !power_down && !thermal_shutdown |-> ##2 cfg_out == $past(cfg_in, 2); endproperty
	property p_frz; s_frozen |-> $stable(cfg_out) && $stable(pull_up); endproperty
	property p_pull; pull_up == (cfg_out.pull_up & ~cfg_out.pull_down) && pull_down == (cfg_out.pull_down & ~cfg_out.pull_up); endproperty
	property p_i2c; alt_en.i2c_pin_enable |=> pin_out[1:0] == 2'h0 && pin_oe_n[1:0] == ~$past({alt_drv.i2c_sda_low, alt_drv.i2c_scl_low}); endproperty
	property p_rf; alt_en.rf_serial_out_pin_enable |=> !pin_oe_n[2] && pin_out[2] == $past(alt_drv.rf_tx_data); endproperty
	property p_ssn; alt_en.spi_enable && !alt_en.rf_serial_out_pin_enable |=> pin_oe_n[2] == !$past(alt_en.spi_dma_master); endproperty
	property p_mosi; alt_en.spi_enable |=> pin_oe_n[3] == !$past(alt_drv.spi_mosi_drive); endproperty
	property p_uart; alt_en.uart_enable && !alt_en.spi_enable |=> !pin_oe_n[3] && pin_out[3] == $past(alt_drv.uart_tx) && pin_oe_n[4]; endproperty
	property p_pwm; alt_en.pwm_enable && !alt_en.spi_enable && !alt_en.rf_serial_out_pin_enable |=> !pin_oe_n[2] && pin_out[2] == $past(alt_drv.pwm_ch0); endproperty
	property p_boot; $rose(rst_n) |-> s_boot; endproperty
	property p_hold; boot_valid |=> boot_valid && $stable(boot_mode); endproperty
	a_cfg: assert property (p_cfg) else $error("config readback wrong");
	a_frz: assert property (p_frz) else $error("config moved while frozen");
	a_pull: assert property (p_pull) else $error("pull outputs wrong");
	a_i2c: assert property (p_i2c) else $error("i2c pins wrong");
	a_rf: assert property (p_rf) else $error("rf output pin wrong");
	a_ssn: assert property (p_ssn) else $error("select direction wrong");
	a_mosi: assert property (p_mosi) else $error("mosi drive wrong");
	a_uart: assert property (p_uart) else $error("uart pins wrong");
	a_pwm: assert property (p_pwm) else $error("pwm pin wrong");
	a_boot: assert property (p_boot) else $error("boot not taken in time");
	a_hold: assert property (p_hold) else $error("boot mode moved");
endmodule
bind iop_port iop_chk #(.PINS(PINS)) i_iop_chk (.clk, .rst_n, .cfg_write, .cfg_in, .power_down, .thermal_shutdown,
	.alt_en, .alt_drv, .pin_out, .pin_oe_n, .pull_up, .pull_down, .cfg_out, .boot_mode, .boot_valid);

// ===== testbench/iop_board.sv
// board side of the six pins: device drive, outside driver, pulls
`timescale 1ns/1ps
module iop_board (
	input wire logic clk, // clock
	input wire logic [5:0] pin_out, // device levels
	input wire logic [5:0] pin_oe_n, // device drive, low drives
	input wire logic [5:0] pull_up, // pull-ups
	input wire logic [5:0] pull_down, // pull-downs
	input wire logic [5:0] ext_oe, // outside driver on
	input wire logic [5:0] ext_val, // outside driver level
	output logic [5:0] pin_in // resolved levels
);
	// a floating pin toggles so a stale value is never mistaken for a read
	logic [5:0] noise = 6'h2A;
	always @(posedge clk) begin
		noise <= ~noise;
	end
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] :
				pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : noise[i];
		end
	end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the six-pin port
`timescale 1ns/1ps
module tb
	import iop_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_write = 1'b0;
	logic power_down = 1'b0;
	logic thermal_shutdown = 1'b0;
	logic idle = 1'b0;
	iop_cfg_type cfg_in = '0;
	iop_cfg_type c;
	iop_alt_en_type alt_en = '0;
	iop_alt_drv_type alt_drv = '0;
	logic [5:0] ext_oe = 6'h00;
	logic [5:0] ext_val = 6'h00;
	logic [5:0] pin_in, pin_out, pin_oe_n, pull_up, pull_down, pin_read;
	iop_cfg_type cfg_out;
	iop_alt_in_type alt_in;
	iop_boot_type boot_mode;
	logic wake_request, boot_valid;
	logic [1:0] wk [3] = '{2'h1, 2'h2, 2'h0};
	logic [6:0] ae [3] = '{7'h5D, 7'h55, 7'h45};
	logic eo [3] = '{1'b0, 1'b1, 1'b0};
	logic eu [3] = '{1'b0, 1'b0, 1'b1};
	iop_boot_type modes [3] = '{BOOT_DEBUG, BOOT_PROGRAM, BOOT_NORMAL};
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	always #10 clk = ~clk;
	iop_port i_iop_port (.clk, .rst_n, .cfg_write, .cfg_in, .power_down, .thermal_shutdown, .idle, .alt_en, .alt_drv,
		.pin_in, .pin_out, .pin_oe_n, .pull_up, .pull_down, .pin_read, .cfg_out, .alt_in, .wake_request, .boot_mode,
		.boot_valid);
	iop_board i_iop_board (.clk, .pin_out, .pin_oe_n, .pull_up, .pull_down, .ext_oe, .ext_val, .pin_in);
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// outputs are looked at mid-cycle, clear of the edge updates
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wcfg(input iop_cfg_type v);
		@(posedge clk);
		cfg_in <= v;
		cfg_write <= 1'b1;
		@(posedge clk);
		cfg_write <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			ext_oe <= 6'h03;
			ext_val <= {4'h0, modes[i] == BOOT_DEBUG ? 2'h1 : modes[i] == BOOT_PROGRAM ? 2'h2 : 2'h3};
			rst_n <= 1'b0;
			repeat (8) @(posedge clk);
			rst_n <= 1'b1;
			look(12);
			chk({boot_valid, boot_mode}, {1'b1, modes[i]});
		end
		c = {6'h3F, 6'h2A, 6'h05, 6'h06, 6'h10, 6'h10};
		wcfg(c);
		look(2);
		chk(cfg_out, c);
		chk({pin_oe_n, pin_out}, 12'h02A);
		chk({pull_up, pull_down}, 12'h042);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			{thermal_shutdown, power_down} <= 2'(k + 1);
			wcfg(~c);
			look(2);
			chk(cfg_out, c);
			@(posedge clk);
			{thermal_shutdown, power_down} <= 2'h0;
		end
		@(posedge clk);
		ext_oe <= 6'h3F;
		ext_val <= 6'h15;
		wcfg({24'h0, 6'h10, 6'h10});
		look(8);
		chk(pin_read, 6'h15);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			{power_down, idle} <= wk[k];
			look(2);
			chk(wake_request, k < 2);
		end
		@(posedge clk);
		ext_val <= 6'h30;
		alt_drv <= 13'h1005;
		alt_en <= 7'h5F;
		look(8);
		chk({pin_oe_n, pin_out[2:0]}, 9'h1D4);
		chk({alt_in.ext_clk_in, alt_in.spi_sclk_in}, 2'h2);
		chk(alt_in, 8'h05);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			alt_en <= ae[k];
			look(1);
			chk(pin_oe_n[2], eo[k]);
			if (!eo[k]) begin
				chk(pin_out[2], eu[k]);
			end
		end
		@(posedge clk);
		alt_en <= 7'h20;
		alt_drv <= 13'h0400;
		look(8);
		chk({alt_in.uart_rx_in, pin_oe_n[4:3], pin_out[3]}, 4'hD);
		chk(alt_in, 8'h20);
		results();
	end
endmodule
